// File: hdl/fla_defines.svh
`ifndef FLA_DEFINES_SVH
`define FLA_DEFINES_SVH
// Contract
// - on a generic stream, 3-byte labels (label_type 1) are matched to unicast addresses
// - at least two unicast interfaces; interface 0 is management with virtual_network 0
// - a unicast address is a virtual_network field followed by a terminal-unique field
// - on a transport-packet stream the 48-bit hardware_identifier is the unicast address
// - each user interface uses the multicast mapping scheme chosen at logon
// - autonomous synthesis: virtual_network bits on top, n low bits of IP MAC below
// - when enabled, bit n+1 tells the IP version, 1 for IPv6, 0 for IPv4
// - bits between the copied low bits and the virtual_network prefix are all 1
// - table-managed multicast mapping works on every user interface
// - single stream header: stream_type_byte 011000YY, length equals payload size, sync 0x01
// - multi stream header: stream_type_byte 010x00YY, second byte is stream_identifier, sync 0x01
// - sync 0xB9 encrypted, 0xBA encrypted with clock header, 0xBB-0xCF reserved, 0xD0+ private
// - short or long frames, alone or mixed with dummy frames, are received
// - any mix of normal, short and dummy frames is received without loss
// - scrambling sequence 0 is always accepted; others are optional
// - constant coding is handled as an adaptive link fixed on one mode
// - sync 0x01 means the last four data bytes hold a CRC32 over the rest
`define FLA_LBL_W 24
`define FLA_HDR_LAST 4'h9
`define FLA_HB_SID 4'h1
`define FLA_HB_DFL_HI 4'h4
`define FLA_HB_DFL_LO 4'h5
`define FLA_HB_SYNC 4'h6
`define FLA_ST_SINGLE 6'h18
`define FLA_ST_MULTI_HI 3'h2
`define FLA_ST_MULTI_LO 2'h0
`define FLA_SYNC_GSE 8'h00
`define FLA_SYNC_GSE_CRC 8'h01
`define FLA_SYNC_ENC 8'hB9
`define FLA_SYNC_ENC_NCR 8'hBA
`define FLA_SYNC_RSV_LO 8'hBB
`define FLA_SYNC_RSV_HI 8'hCF
`define FLA_SYNC_PRIV_LO 8'hD0
`define FLA_CRC_BYTES 13'h0004
`define FLA_CRC_INIT 32'hFFFFFFFF
`define FLA_CRC_POLY 32'h04C11DB7
`define FLA_LT_6B 2'h0
`define FLA_LT_3B 2'h1
`define FLA_LT_NONE 2'h2
`define FLA_SCR_BROADCAST 18'h00000
`endif

// File: hdl/fla_pkg.sv
package fla_pkg;
  typedef enum logic [1:0] {
    FLA_IDLE = 2'b00,
    FLA_HDR = 2'b01,
    FLA_DATA = 2'b11,
    FLA_SKIP = 2'b10
  } fla_state_t;
  typedef enum logic [2:0] {
    FLA_SC_GSE = 3'h0,
    FLA_SC_GSE_CRC = 3'h1,
    FLA_SC_ENC = 3'h2,
    FLA_SC_ENC_NCR = 3'h3,
    FLA_SC_RSV = 3'h4,
    FLA_SC_PRIV = 3'h5,
    FLA_SC_OTHER = 3'h6
  } fla_sync_t;
endpackage

// File: hdl/fla_crc32.sv
`timescale 1ns/100ps
`include "fla_defines.svh"
module fla_crc32 (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [31:0] crc_q
);
  // msb-first byte update, no reflection, no final inversion
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ `FLA_CRC_POLY;
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!resetn || clr) begin
      crc_q <= `FLA_CRC_INIT;
    end else if (en) begin
      crc_q <= crc_byte(crc_q, din);
    end
  end
endmodule

// File: hdl/fla_rx_filter.sv
`timescale 1ns/100ps
`include "fla_defines.svh"
module fla_rx_filter
  import fla_pkg::*;
#(
  parameter int N_IF = 2,
  parameter int N_MC = 8,
  parameter int SVN_W = 8,
  parameter bit SCR_ANY_OK = 1'b0
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cfg_ts_mode,
  input wire logic cfg_single,
  input wire logic [7:0] cfg_stream_id,
  input wire logic [47:0] cfg_hw_id,
  input wire logic [N_IF*`FLA_LBL_W-1:0] cfg_ucast,
  input wire logic [N_IF-1:0] cfg_if_en,
  input wire logic [N_IF-1:0] cfg_mc_table,
  input wire logic [4:0] cfg_mc_n,
  input wire logic cfg_mc_ver_en,
  input wire logic fr_valid,
  input wire logic fr_start,
  input wire logic fr_dummy,
  input wire logic [15:0] fr_kbch,
  input wire logic [17:0] fr_scr,
  input wire logic [7:0] fr_byte,
  input wire logic mc_wr,
  input wire logic [$clog2(N_MC)-1:0] mc_idx,
  input wire logic mc_keep,
  input wire logic [$clog2(N_IF)-1:0] mc_if,
  input wire logic [47:0] mc_ip_mac,
  input wire logic mc_v6,
  input wire logic [`FLA_LBL_W-1:0] mc_tbl_label,
  input wire logic lbl_valid,
  input wire logic [1:0] lbl_type,
  input wire logic [47:0] lbl_addr,
  output logic hdr_ok_q,
  output logic hdr_err_q,
  output fla_sync_t sync_cls_q,
  output logic dat_valid_q,
  output logic [7:0] dat_byte_q,
  output logic dat_last_q,
  output logic dat_crc_fld_q,
  output logic crc_ok_q,
  output logic crc_err_q,
  output logic lbl_pass_q,
  output logic lbl_drop_q,
  output logic lbl_mcast_q,
  output logic [$clog2(N_IF)-1:0] lbl_if_q
);
  localparam int IFW = $clog2(N_IF);
  localparam int MCW = $clog2(N_MC);
  localparam int LW = `FLA_LBL_W;

  ////////////////////////////////////////////////////////////////////////////////
  fla_state_t state_q;
  logic [3:0] hcnt_q;
  logic [7:0] st_q;
  logic [7:0] sid_q;
  logic [15:0] dfl_q;
  logic [7:0] sync_q;
  logic [15:0] kbch_q;
  logic [17:0] scr_q;
  logic [12:0] dcnt_q;
  logic [23:0] crc_rx_q;
  logic [31:0] crc_val;
  logic type_ok, sid_ok, len_ok, scr_ok, sync_ok, hdr_fail;
  logic hdr_end, dat_ev, crc_mode, crc_en, start_ev;
  fla_sync_t sync_d;

  function automatic fla_sync_t sync_class(input logic [7:0] s);
    if (s == `FLA_SYNC_GSE) return FLA_SC_GSE;
    if (s == `FLA_SYNC_GSE_CRC) return FLA_SC_GSE_CRC;
    if (s == `FLA_SYNC_ENC) return FLA_SC_ENC;
    if (s == `FLA_SYNC_ENC_NCR) return FLA_SC_ENC_NCR;
    if (s >= `FLA_SYNC_RSV_LO && s <= `FLA_SYNC_RSV_HI) return FLA_SC_RSV;
    if (s >= `FLA_SYNC_PRIV_LO) return FLA_SC_PRIV;
    return FLA_SC_OTHER;
  endfunction

  function automatic logic [SVN_W-1:0] svn_of(input logic [LW-1:0] a);
    return a[LW-1 -: SVN_W];
  endfunction

  function automatic logic [LW-1:0] mc_synth(input logic [SVN_W-1:0] virtual_network, input logic [47:0] ipm,
                                             input logic v6, input logic [4:0] n, input logic ver_en);
    logic [LW-1:0] r;
    r = {LW{1'b1}}; // filler bits between copied part and prefix
    r[LW-1 -: SVN_W] = virtual_network;
    for (int i = 0; i < LW - SVN_W; i++) begin
      if (i < int'(n)) begin
        r[i] = ipm[i];
      end else if (i == int'(n) && ver_en) begin
        r[i] = v6;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // frame header checks
  assign start_ev = fr_valid && fr_start;
  assign hdr_end = fr_valid && !fr_start && state_q == FLA_HDR && hcnt_q == `FLA_HDR_LAST;
  assign dat_ev = fr_valid && !fr_start && state_q == FLA_DATA;
  assign sync_d = sync_class(sync_q);
  // constant coding uses the same adaptive-format header
  assign type_ok = cfg_single ? (st_q[7:2] == `FLA_ST_SINGLE)
                              : (st_q[7:5] == `FLA_ST_MULTI_HI && st_q[3:2] == `FLA_ST_MULTI_LO);
  assign sid_ok = cfg_single || sid_q == cfg_stream_id;
  assign len_ok = dfl_q == kbch_q && dfl_q[15:3] != 13'h0000 &&
                  !(sync_q == `FLA_SYNC_GSE_CRC && dfl_q[15:3] <= `FLA_CRC_BYTES);
  assign scr_ok = scr_q == `FLA_SCR_BROADCAST || SCR_ANY_OK;
  assign sync_ok = sync_d != FLA_SC_RSV && sync_d != FLA_SC_OTHER;
  assign hdr_fail = !(type_ok && len_ok && scr_ok && sync_ok);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= FLA_IDLE;
    end else if (start_ev) begin
      state_q <= fr_dummy ? FLA_SKIP : FLA_HDR; // dummy frames carry nothing
    end else if (fr_valid) begin
      case (state_q)
        FLA_HDR: begin
          if (hcnt_q == `FLA_HDR_LAST) begin
            state_q <= (sid_ok && !hdr_fail) ? FLA_DATA : FLA_SKIP;
          end
        end
        FLA_DATA: begin
          if (dcnt_q == 13'h0001) begin
            state_q <= FLA_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hcnt_q <= 4'h0;
      st_q <= 8'h00;
      sid_q <= 8'h00;
      dfl_q <= 16'h0000;
      sync_q <= 8'h00;
      kbch_q <= 16'h0000;
      scr_q <= 18'h00000;
    end else if (start_ev) begin
      hcnt_q <= 4'h1;
      st_q <= fr_byte;
      kbch_q <= fr_kbch;
      scr_q <= fr_scr;
    end else if (fr_valid && state_q == FLA_HDR) begin
      hcnt_q <= hcnt_q + 4'h1;
      if (hcnt_q == `FLA_HB_SID) begin
        sid_q <= fr_byte;
      end
      if (hcnt_q == `FLA_HB_DFL_HI) begin
        dfl_q[15:8] <= fr_byte;
      end
      if (hcnt_q == `FLA_HB_DFL_LO) begin
        dfl_q[7:0] <= fr_byte;
      end
      if (hcnt_q == `FLA_HB_SYNC) begin
        sync_q <= fr_byte;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hdr_ok_q <= 1'b0;
      hdr_err_q <= 1'b0;
      sync_cls_q <= FLA_SC_GSE;
    end else begin
      hdr_ok_q <= hdr_end && sid_ok && !hdr_fail;
      hdr_err_q <= hdr_end && sid_ok && hdr_fail;
      if (hdr_end) begin
        sync_cls_q <= sync_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data field and trailing checksum
  assign crc_mode = sync_cls_q == FLA_SC_GSE_CRC;
  assign crc_en = dat_ev && crc_mode && dcnt_q > `FLA_CRC_BYTES;

  fla_crc32 u_crc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clr(start_ev),
    .en(crc_en),
    .din(fr_byte),
    .crc_q(crc_val)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dcnt_q <= 13'h0000;
      crc_rx_q <= 24'h000000;
    end else if (hdr_end) begin
      dcnt_q <= dfl_q[15:3];
    end else if (dat_ev) begin
      dcnt_q <= dcnt_q - 13'h0001;
      crc_rx_q <= {crc_rx_q[15:0], fr_byte};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dat_valid_q <= 1'b0;
      dat_byte_q <= 8'h00;
      dat_last_q <= 1'b0;
      dat_crc_fld_q <= 1'b0;
      crc_ok_q <= 1'b0;
      crc_err_q <= 1'b0;
    end else begin
      dat_valid_q <= dat_ev;
      dat_last_q <= dat_ev && dcnt_q == 13'h0001;
      dat_crc_fld_q <= dat_ev && crc_mode && dcnt_q <= `FLA_CRC_BYTES;
      if (dat_ev) begin
        dat_byte_q <= fr_byte;
      end
      crc_ok_q <= dat_ev && crc_mode && dcnt_q == 13'h0001 && {crc_rx_q, fr_byte} == crc_val;
      crc_err_q <= dat_ev && crc_mode && dcnt_q == 13'h0001 && {crc_rx_q, fr_byte} != crc_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // unicast and multicast address tables
  logic [LW-1:0] uc_addr [N_IF];
  logic [N_IF-1:0] uc_hit;
  logic [LW-1:0] mc_lbl_q [N_MC];
  logic [IFW-1:0] mc_if_q [N_MC];
  logic [N_MC-1:0] mc_val_q;
  logic [N_MC-1:0] mc_hit;

  genvar g;
  generate
    for (g = 0; g < N_IF; g++) begin : g_uc
      if (g == 0) begin : g_mgmt
        // management interface is pinned to virtual_network 0
        assign uc_addr[g] = {{SVN_W{1'b0}}, cfg_ucast[g*LW +: LW-SVN_W]};
      end else begin : g_user
        assign uc_addr[g] = cfg_ucast[g*LW +: LW];
      end
      assign uc_hit[g] = cfg_if_en[g] && lbl_addr[LW-1:0] == uc_addr[g];
    end
    for (g = 0; g < N_MC; g++) begin : g_mc
      assign mc_hit[g] = mc_val_q[g] && lbl_addr[LW-1:0] == mc_lbl_q[g];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < N_MC; i++) begin
        mc_val_q[i] <= 1'b0;
        mc_lbl_q[i] <= {LW{1'b0}};
        mc_if_q[i] <= {IFW{1'b0}};
      end
    end else if (mc_wr) begin
      mc_val_q[mc_idx] <= mc_keep;
      mc_if_q[mc_idx] <= mc_if;
      // per-interface scheme, table entries allowed on every interface
      mc_lbl_q[mc_idx] <= cfg_mc_table[mc_if] ? mc_tbl_label
                         : mc_synth(svn_of(uc_addr[mc_if]), mc_ip_mac, mc_v6, cfg_mc_n, cfg_mc_ver_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // label decision
  logic lbl_ok;
  logic lbl_is_mc;
  logic [IFW-1:0] hit_if;

  always_comb begin
    hit_if = {IFW{1'b0}};
    for (int i = N_MC - 1; i >= 0; i--) begin
      if (mc_hit[i]) begin
        hit_if = mc_if_q[i];
      end
    end
    for (int i = N_IF - 1; i >= 0; i--) begin
      if (uc_hit[i]) begin
        hit_if = IFW'(i);
      end
    end
  end

  always_comb begin
    lbl_is_mc = 1'b0;
    if (cfg_ts_mode) begin
      lbl_ok = lbl_type == `FLA_LT_6B && lbl_addr == cfg_hw_id; // no network separation
    end else begin
      case (lbl_type)
        `FLA_LT_6B: lbl_ok = lbl_addr == cfg_hw_id;
        `FLA_LT_3B: begin
          lbl_ok = |uc_hit || |mc_hit;
          lbl_is_mc = !(|uc_hit) && |mc_hit;
        end
        `FLA_LT_NONE: lbl_ok = 1'b1;
        default: lbl_ok = 1'b0; // label re-use is never valid
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lbl_pass_q <= 1'b0;
      lbl_drop_q <= 1'b0;
      lbl_mcast_q <= 1'b0;
      lbl_if_q <= {IFW{1'b0}};
    end else begin
      lbl_pass_q <= lbl_valid && lbl_ok;
      lbl_drop_q <= lbl_valid && !lbl_ok;
      lbl_mcast_q <= lbl_valid && lbl_ok && lbl_is_mc;
      if (lbl_valid) begin
        lbl_if_q <= hit_if;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_dummy_skip: assert property (@(posedge clk_sys) disable iff (!resetn)
    (start_ev && fr_dummy) |=> (state_q == FLA_SKIP) ##1 !hdr_ok_q)
    else $error("dummy frame not skipped");

  a_single_type: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hdr_ok_q && $past(cfg_single)) |-> ($past(st_q[7:2]) == `FLA_ST_SINGLE && $past(dfl_q) == $past(kbch_q)))
    else $error("single stream header accepted with bad type or length");

  a_stream_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hdr_end && !cfg_single && sid_q != cfg_stream_id) |=> (!hdr_ok_q && !hdr_err_q && state_q == FLA_SKIP))
    else $error("foreign stream not skipped silently");

  a_sync_enc: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hdr_end && sync_q == `FLA_SYNC_ENC_NCR) |=> (sync_cls_q == FLA_SC_ENC_NCR))
    else $error("sync 0xBA misclassified");

  a_crc_at_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    (crc_ok_q || crc_err_q) |-> (dat_last_q && dat_crc_fld_q && $past(crc_mode)))
    else $error("checksum verdict off the last byte");

  a_crc_field: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dat_ev && crc_mode && dcnt_q == 13'h0004) |=> dat_crc_fld_q [*1] ##1 1'b1)
    else $error("checksum field not marked");

  a_ucast_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
    (lbl_valid && !cfg_ts_mode && lbl_type == `FLA_LT_3B && |uc_hit) |=> (lbl_pass_q && !lbl_mcast_q))
    else $error("unicast label not accepted");

  a_nomatch_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
    (lbl_valid && lbl_type == `FLA_LT_3B && !(|uc_hit) && !(|mc_hit)) |=> (lbl_drop_q && !lbl_pass_q))
    else $error("unmatched label forwarded");

  a_hid_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
    (lbl_valid && cfg_ts_mode && lbl_type == `FLA_LT_6B && lbl_addr == cfg_hw_id) |=> lbl_pass_q)
    else $error("hardware identifier traffic refused");

  a_mc_lowbit: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mc_wr && mc_keep && !cfg_mc_table[mc_if] && cfg_mc_n != 5'h00)
      |=> (mc_lbl_q[$past(mc_idx)][0] == $past(mc_ip_mac[0]) && mc_val_q[$past(mc_idx)]))
    else $error("synthesized multicast low bit wrong");

  a_mc_prefix: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mc_wr && !cfg_mc_table[mc_if] && int'(cfg_mc_n) < LW - SVN_W - 1)
      |=> mc_lbl_q[$past(mc_idx)][LW-SVN_W-1])
    else $error("filler bits not all ones");
endmodule

// File: verif/fla_feeder.sv
`timescale 1ns/100ps
`include "fla_defines.svh"
module fla_feeder (
  input wire logic clk_sys,
  output logic fr_valid,
  output logic fr_start,
  output logic fr_dummy,
  output logic [15:0] fr_kbch,
  output logic [17:0] fr_scr,
  output logic [7:0] fr_byte
);
  initial begin
    fr_valid = 1'b0;
    fr_start = 1'b0;
    fr_dummy = 1'b0;
    fr_kbch = 16'h0000;
    fr_scr = 18'h00000;
    fr_byte = 8'h5A;
  end

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {b, 24'h000000};
    for (int k = 0; k < 8; k++)
      c = c[31] ? ((c << 1) ^ `FLA_CRC_POLY) : (c << 1);
    return c;
  endfunction

  // released bus shows the inverse of the last byte
  task automatic idle();
    @(negedge clk_sys);
    fr_valid = 1'b0;
    fr_start = 1'b0;
    fr_byte = ~fr_byte;
  endtask

  // one frame: 10 header bytes then nb data bytes, crc in the last four
  // only declared modes are used and none is ever withdrawn
  task automatic send(input logic [7:0] st, input logic [7:0] sid, input logic [7:0] sync, input int nb,
                      input logic [15:0] koff, input logic [17:0] scr, input logic dummy,
                      input logic bad, input logic gap);
    logic [7:0] fb [$];
    logic [31:0] c;
    logic [15:0] data_field_length;
    c = `FLA_CRC_INIT;
    data_field_length = 16'(nb * 8);
    fb = {st, sid, 8'h00, 8'h00, data_field_length[15:8], data_field_length[7:0], sync, 8'h00, 8'h00, 8'h00};
    for (int j = 0; j < nb - 4; j++) begin
      fb.push_back(8'(j * 7 + 3));
      c = crc_step(c, fb[$]);
    end
    if (bad)
      c = ~c;
    for (int j = 3; j >= 0; j--)
      fb.push_back(c[j*8+:8]);
    foreach (fb[i]) begin
      if (gap && i[0])
        idle();
      @(negedge clk_sys);
      fr_valid = 1'b1;
      fr_start = (i == 0);
      fr_dummy = dummy;
      fr_kbch = data_field_length + koff;
      fr_scr = scr;
      fr_byte = fb[i];
    end
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import fla_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, cfg_ts_mode = 1'b0, cfg_single = 1'b1, cfg_mc_ver_en = 1'b1;
  logic [7:0] cfg_stream_id = 8'h2C;
  logic [47:0] cfg_hw_id = 48'h0A1B2C3D4E5F;
  logic [47:0] cfg_ucast = {24'h05ABCD, 24'h001234};
  logic [1:0] cfg_if_en = 2'b11, cfg_mc_table = 2'b00, lbl_type = 2'h0;
  logic [4:0] cfg_mc_n = 5'h0A;
  logic fr_valid, fr_start, fr_dummy, mc_wr = 1'b0, mc_keep = 1'b0, mc_if = 1'b0, mc_v6 = 1'b0, lbl_valid = 1'b0;
  logic [15:0] fr_kbch;
  logic [17:0] fr_scr;
  logic [7:0] fr_byte;
  logic [2:0] mc_idx = 3'h0;
  logic [47:0] mc_ip_mac = 48'h0, lbl_addr = 48'h0;
  logic [23:0] mc_tbl_label = 24'h0;
  logic hdr_ok_q, hdr_err_q, dat_valid_q, dat_last_q, dat_crc_fld_q, crc_ok_q, crc_err_q;
  logic lbl_pass_q, lbl_drop_q, lbl_mcast_q, lbl_if_q;
  logic [7:0] dat_byte_q;
  fla_sync_t sync_cls_q;
  int failures = 0, checked = 0, n_hok, n_herr, n_dat, n_fld, n_cok, n_cerr, n_last, bi;
  localparam logic [47:0] MAC = 48'h01005E7F1234;
  localparam logic [7:0] SV [8] = '{8'hB9, 8'hBA, 8'hBB, 8'hCF, 8'hD0, 8'hFF, 8'h00, 8'h02};
  localparam fla_sync_t SC [8] = '{FLA_SC_ENC, FLA_SC_ENC_NCR, FLA_SC_RSV, FLA_SC_RSV, FLA_SC_PRIV, FLA_SC_PRIV,
    FLA_SC_GSE, FLA_SC_OTHER};

  always #5 clk_sys = ~clk_sys;

  fla_feeder u_feed (.clk_sys(clk_sys), .fr_valid(fr_valid), .fr_start(fr_start), .fr_dummy(fr_dummy),
    .fr_kbch(fr_kbch), .fr_scr(fr_scr), .fr_byte(fr_byte));

  fla_rx_filter u_dut (.clk_sys(clk_sys), .resetn(resetn), .cfg_ts_mode(cfg_ts_mode), .cfg_single(cfg_single),
    .cfg_stream_id(cfg_stream_id), .cfg_hw_id(cfg_hw_id), .cfg_ucast(cfg_ucast), .cfg_if_en(cfg_if_en),
    .cfg_mc_table(cfg_mc_table), .cfg_mc_n(cfg_mc_n), .cfg_mc_ver_en(cfg_mc_ver_en), .fr_valid(fr_valid),
    .fr_start(fr_start), .fr_dummy(fr_dummy), .fr_kbch(fr_kbch), .fr_scr(fr_scr), .fr_byte(fr_byte),
    .mc_wr(mc_wr), .mc_idx(mc_idx), .mc_keep(mc_keep), .mc_if(mc_if), .mc_ip_mac(mc_ip_mac), .mc_v6(mc_v6),
    .mc_tbl_label(mc_tbl_label), .lbl_valid(lbl_valid), .lbl_type(lbl_type), .lbl_addr(lbl_addr),
    .hdr_ok_q(hdr_ok_q), .hdr_err_q(hdr_err_q), .sync_cls_q(sync_cls_q), .dat_valid_q(dat_valid_q),
    .dat_byte_q(dat_byte_q), .dat_last_q(dat_last_q), .dat_crc_fld_q(dat_crc_fld_q), .crc_ok_q(crc_ok_q),
    .crc_err_q(crc_err_q), .lbl_pass_q(lbl_pass_q), .lbl_drop_q(lbl_drop_q), .lbl_mcast_q(lbl_mcast_q),
    .lbl_if_q(lbl_if_q));

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (hdr_ok_q === 1'b1) n_hok++;
    if (hdr_err_q === 1'b1) n_herr++;
    if (dat_valid_q === 1'b1) n_dat++;
    if (dat_crc_fld_q === 1'b1) n_fld++;
    if (crc_ok_q === 1'b1) n_cok++;
    if (crc_err_q === 1'b1) n_cerr++;
    if (dat_last_q === 1'b1) n_last++;
    // first four data bytes of every frame follow the feeder's fill pattern
    if (dat_valid_q === 1'b1) begin
      if (bi < 4)
        chk(dat_byte_q === 8'(bi * 7 + 3), "data byte");
      bi = (dat_last_q === 1'b1) ? 0 : bi + 1;
    end
  end

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic clr();
    @(negedge clk_sys);
    {n_hok, n_herr, n_dat, n_fld, n_cok, n_cerr, n_last} = '0;
  endtask

  task automatic ex(input int h, input int e, input int co, input int ce, input int nd);
    u_feed.idle();
    repeat (3) @(negedge clk_sys);
    chk(n_hok == h && n_herr == e && n_cok == co && n_cerr == ce && n_dat == nd && n_last == h, "frame outcome");
  endtask

  task automatic lbl(input logic [1:0] t, input logic [47:0] a, input logic p, input logic m, input logic ix);
    @(negedge clk_sys);
    lbl_valid = 1'b1;
    lbl_type = t;
    lbl_addr = a;
    @(negedge clk_sys);
    lbl_valid = 1'b0;
    chk(lbl_pass_q === p && lbl_drop_q === !p && lbl_mcast_q === m, "label verdict");
    if (p && t == 2'h1)
      chk(lbl_if_q === ix, "label interface");
  endtask

  task automatic mcw(input logic [2:0] i, input logic k, input logic v6, input logic [23:0] tl);
    @(negedge clk_sys);
    {mc_wr, mc_idx, mc_keep, mc_if, mc_ip_mac, mc_v6, mc_tbl_label} = {1'b1, i, k, 1'b1, MAC, v6, tl};
    @(negedge clk_sys);
    mc_wr = 1'b0;
  endtask

  function automatic logic [47:0] syn(input logic v6, input logic ver);
    logic [23:0] l;
    l = {8'h05, 16'hFFFF};
    for (int i = 0; i < 16; i++)
      if (i < 10) l[i] = MAC[i];
      else if (i == 10 && ver) l[i] = v6;
    return {24'h000000, l};
  endfunction

  task automatic final_report();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_labels();
    lbl(2'h1, 48'h05ABCD, 1, 0, 1);
    lbl(2'h1, 48'h001234, 1, 0, 0);
    lbl(2'h1, 48'h06ABCD, 0, 0, 0);
    lbl(2'h0, cfg_hw_id, 1, 0, 0);
    lbl(2'h0, cfg_hw_id ^ 48'h1, 0, 0, 0);
    lbl(2'h2, 48'h0, 1, 0, 0);
    lbl(2'h3, 48'h05ABCD, 0, 0, 0);
    cfg_if_en = 2'b01;
    lbl(2'h1, 48'h05ABCD, 0, 0, 0);
    cfg_if_en = 2'b11;
    cfg_ts_mode = 1'b1;
    lbl(2'h0, cfg_hw_id, 1, 0, 0);
    lbl(2'h1, 48'h05ABCD, 0, 0, 0);
    cfg_ts_mode = 1'b0;
  endtask

  task automatic t_mcast();
    mcw(3'h0, 1'b1, 1'b0, 24'h0);
    lbl(2'h1, syn(1'b0, 1'b1), 1, 1, 1);
    lbl(2'h1, syn(1'b1, 1'b1), 0, 0, 0);
    mcw(3'h1, 1'b1, 1'b1, 24'h0);
    lbl(2'h1, syn(1'b1, 1'b1), 1, 1, 1);
    cfg_mc_ver_en = 1'b0;
    lbl(2'h1, syn(1'b0, 1'b0), 1, 1, 1);
    mcw(3'h0, 1'b0, 1'b0, 24'h0);
    mcw(3'h1, 1'b0, 1'b0, 24'h0);
    lbl(2'h1, syn(1'b0, 1'b0), 0, 0, 0);
    cfg_mc_table = 2'b10;
    mcw(3'h2, 1'b1, 1'b0, 24'h057777);
    lbl(2'h1, 48'h057777, 1, 1, 1);
    lbl(2'h1, syn(1'b0, 1'b0), 0, 0, 0);
  endtask

  task automatic t_frames();
    clr();
    u_feed.send(8'h61, 8'hAA, 8'h01, 16, 0, 0, 0, 0, 0);
    ex(1, 0, 1, 0, 16);
    chk(n_fld == 4 && sync_cls_q === FLA_SC_GSE_CRC, "crc field");
    clr();
    u_feed.send(8'h62, 8'h00, 8'h01, 12, 0, 0, 0, 1, 1);
    ex(1, 0, 0, 1, 12);
    clr();
    u_feed.send(8'h61, 8'h00, 8'h01, 12, 8, 0, 0, 0, 0);
    ex(0, 1, 0, 0, 0);
    clr();
    u_feed.send(8'h41, 8'h2C, 8'h01, 12, 0, 0, 0, 0, 0);
    ex(0, 1, 0, 0, 0);
    clr();
    u_feed.send(8'h61, 8'h00, 8'h01, 12, 0, 18'h1, 0, 0, 0);
    ex(0, 1, 0, 0, 0);
    for (int i = 0; i < 8; i++) begin
      logic rj;
      rj = SC[i] inside {FLA_SC_RSV, FLA_SC_OTHER};
      clr();
      u_feed.send(8'h61, 8'h00, SV[i], 8, 0, 0, 0, 0, 0);
      ex(!rj, rj, 0, 0, rj ? 0 : 8);
      if (!rj)
        chk(sync_cls_q === SC[i], "sync class");
    end
    clr();
    u_feed.send(8'h61, 8'h00, 8'h01, 8, 0, 0, 1, 0, 0);
    u_feed.send(8'h61, 8'h00, 8'h01, 8, 0, 0, 0, 0, 0);
    u_feed.send(8'h60, 8'h00, 8'h01, 60, 0, 0, 0, 0, 0);
    u_feed.send(8'h61, 8'h00, 8'h01, 60, 0, 0, 1, 0, 0);
    ex(2, 0, 2, 0, 68);
    cfg_single = 1'b0;
    clr();
    u_feed.send(8'h52, 8'h2C, 8'h01, 8, 0, 0, 0, 0, 0);
    u_feed.send(8'h42, 8'h2D, 8'h01, 8, 0, 0, 0, 0, 0);
    u_feed.send(8'h62, 8'h2C, 8'h01, 8, 0, 0, 0, 0, 0);
    ex(1, 1, 1, 0, 8);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    chk(hdr_ok_q === 1'b0 && lbl_pass_q === 1'b0 && dat_valid_q === 1'b0 && sync_cls_q === FLA_SC_GSE, "reset");
    t_labels();
    t_mcast();
    t_frames();
    final_report();
  end
endmodule
